// >>> rtl/brs_params.svh
`ifndef BRS_PARAMS_SVH
`define BRS_PARAMS_SVH

// model register addresses
`define BRS_ADDR_ENTRY_FIRST  12'h040
`define BRS_ADDR_TOP_POINTER  12'h1c9
`define BRS_ADDR_DEBUG_CTRL   12'h1d9
`define BRS_ADDR_LER_SOURCE   12'h1dd
`define BRS_ADDR_LER_DEST     12'h1de

// debug control field positions
`define BRS_BIT_RECORD_EN     0
`define BRS_BIT_STEP_BRANCH   1
`define BRS_BIT_TRACE_MSG     6
`define BRS_BIT_TRACE_STORE   7
`define BRS_BIT_BUF_FULL_IRQ  8
`define BRS_CTRL_WRITE_MASK   64'h0000_0000_0000_01c3
`define BRS_CTRL_RESET        64'h0000_0000_0000_0000

// identification feature bit reporting the debug save area
`define BRS_FEATURE_DS_BIT    21

// stack geometry
`define BRS_DEPTH_SMALL       4
`define BRS_DEPTH_LARGE       16
`define BRS_DEPTH_MID         8
`define BRS_PTR_RESET         4'h0

`endif

// >>> rtl/brs_pkg.sv
package brs_pkg;
  typedef enum logic [1:0] {
    BRS_EV_BRANCH,
    BRS_EV_INTERRUPT,
    BRS_EV_EXCEPTION
  } brs_event_type;

  typedef enum {
    BRS_IDLE,
    BRS_SECOND
  } brs_state_type;

  typedef logic [31:0] brs_addr_type;
endpackage

// >>> rtl/brs_branch_record_stack.sv
// Function
// - advance stack top pointer by one, then store record at the new entry
// - pointer at highest value wraps to zero, overwriting the oldest entry
// - pointer always selects the newest stored record
// - depth build option of 4 or 16 entries (also 8), pointer range follows
// - stack entries and pointer are read only; writes do nothing to them
// - each record is a source and a destination linear address
// - branch stores branch address as source, target as destination
// - interrupt stores return pointer as source, handler start as destination
// - exception stores faulting instruction as source, handler as destination
// - branch raising a trap exception pushes branch record then exception record
// - interrupt right after a branch pushes branch record then interrupt record
// - keep a last exception source and destination register pair
// - control bit 0 enables recording of branches, interrupts and exceptions
// - control bit 1 makes the step flag step on taken branches
// - control bit 6 emits each record as a trace message
// - control bit 7 logs trace messages into the memory trace store
// - bit 8 interrupts when the store fills, else logging wraps
// - eight entry variant holds source in bits 31-0, destination in 63-32
// - eight entry variant pointer is 3 bits in bits 2-0
// - debug control register sits at model register address 01d9
// - feature bit 21 reports the debug save area mechanism
// - last exception source and destination are 32 bits each
// - recording enable clears itself on any debug exception
// - on exception or interrupt, copy last branch into last exception pair first
`timescale 1ns/1ns
`include "brs_params.svh"

module brs_branch_record_stack #(
  parameter int DEPTH = `BRS_DEPTH_MID
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // retired control transfers from the pipeline
  input  wire logic                  xfer_valid_i,
  input  wire brs_pkg::brs_event_type xfer_kind_i,
  input  wire brs_pkg::brs_addr_type xfer_source_i,
  input  wire brs_pkg::brs_addr_type xfer_dest_i,
  input  wire logic                  xfer_with_branch_i,
  input  wire brs_pkg::brs_addr_type branch_source_i,
  input  wire brs_pkg::brs_addr_type branch_dest_i,
  input  wire logic                  debug_exception_i,
  // model register access
  input  wire logic                  reg_read_i,
  input  wire logic                  reg_write_i,
  input  wire logic [11:0]           reg_addr_i,
  input  wire logic [63:0]           reg_wdata_i,
  output logic      [63:0]           reg_rdata_o,
  output logic                       reg_rvalid_o,
  // trace store side, plus pipeline ready, step flag and feature flags
  input  wire logic                  store_full_i,
  output logic                       xfer_ready_o,
  output logic                       step_on_branch_flag_o,
  output logic                       trace_message_valid_o,
  output logic      [63:0]           trace_message_o,
  output logic                       trace_store_valid_o,
  output logic                       store_wrap_o,
  output logic                       buffer_full_irq_o,
  output logic      [31:0]           feature_flags_o
);
  import brs_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [63:0]          stack_mem [DEPTH];
  logic [PW-1:0]        stack_top_pointer;
  logic [63:0]          debug_trace_control;
  brs_addr_type         last_branch_source;
  brs_addr_type         last_branch_dest;
  brs_addr_type         last_exception_source;
  brs_addr_type         last_exception_destination;
  brs_state_type        state;
  brs_addr_type         held_source;
  brs_addr_type         held_dest;
  logic                 push;
  logic [63:0]          push_record;
  logic [PW-1:0]        next_pointer;
  logic                 ctrl_write;
  logic [PW-1:0]        read_index;
  logic                 pair_start;
  logic                 xfer_take;
  brs_state_type        next_state;
  logic [2:0]           reg_sel;
  logic [63:0]          next_rdata;

  // pointer advance wraps at the top of the build-time depth
  function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction

  // source in low word, destination in high word
  function automatic logic [63:0] pack_record(input brs_addr_type src,
                                              input brs_addr_type dst);
    return {dst, src};
  endfunction

  // register map codes shared by the write and read paths
  localparam logic [2:0] SEL_NONE    = 3'h0;
  localparam logic [2:0] SEL_STACK   = 3'h1;
  localparam logic [2:0] SEL_POINTER = 3'h2;
  localparam logic [2:0] SEL_CONTROL = 3'h3;
  localparam logic [2:0] SEL_EXC_SRC = 3'h4;
  localparam logic [2:0] SEL_EXC_DST = 3'h5;

  // stack window is as deep as the build option, so higher offsets read as unmapped
  function automatic logic [2:0] decode_reg(input logic [11:0] a);
    if (a >= `BRS_ADDR_ENTRY_FIRST && a < `BRS_ADDR_ENTRY_FIRST + 12'(DEPTH)) begin
      return SEL_STACK;
    end
    case (a)
      `BRS_ADDR_TOP_POINTER: return SEL_POINTER;
      `BRS_ADDR_DEBUG_CTRL:  return SEL_CONTROL;
      `BRS_ADDR_LER_SOURCE:  return SEL_EXC_SRC;
      `BRS_ADDR_LER_DEST:    return SEL_EXC_DST;
      default:               return SEL_NONE;
    endcase
  endfunction

  wire recording = debug_trace_control[`BRS_BIT_RECORD_EN];
  // a paired transfer needs two cycles, so the second push stalls the pipeline
  assign xfer_ready_o = (state == BRS_IDLE);
  // an interrupt or exception that brings its own branch needs a second push next cycle
  assign pair_start = xfer_valid_i && recording && xfer_with_branch_i
                      && xfer_kind_i != BRS_EV_BRANCH;
  assign xfer_take = xfer_valid_i && xfer_ready_o && recording;

  // choose what goes onto the stack this cycle
  always_comb begin
    push = 1'b0;
    push_record = '0;
    if (state == BRS_SECOND) begin
      push = 1'b1;
      push_record = pack_record(held_source, held_dest);
    end else if (xfer_valid_i && recording) begin
      push = 1'b1;
      if (xfer_with_branch_i && xfer_kind_i != BRS_EV_BRANCH) begin
        push_record = pack_record(branch_source_i, branch_dest_i);
      end else begin
        // sources already carry the right address per kind
        push_record = pack_record(xfer_source_i, xfer_dest_i);
      end
    end
  end

  assign next_pointer = advance(stack_top_pointer);

  // two-step sequence for branch followed by trap or interrupt
  always_comb begin
    next_state = state;
    case (state)
      BRS_IDLE: begin
        if (pair_start) begin
          next_state = BRS_SECOND;
        end
      end
      BRS_SECOND: next_state = BRS_IDLE;
      default: next_state = BRS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= BRS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // the event half of a pair waits here while the branch half is pushed
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      held_source <= '0;
      held_dest <= '0;
    end else if (state == BRS_IDLE && pair_start) begin
      held_source <= xfer_source_i;
      held_dest <= xfer_dest_i;
    end
  end

  // pointer: only hardware moves it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stack_top_pointer <= PW'(`BRS_PTR_RESET);
    end else if (push) begin
      stack_top_pointer <= next_pointer;
    end
  end

  // entries have no reset; contents undefined until written
  always_ff @(posedge clk_i) begin
    if (push) begin
      stack_mem[next_pointer] <= push_record;
    end
  end

  // last exception pair takes a paired branch, else reads the old last branch copy in the same edge it is replaced
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_exception_source <= '0;
      last_exception_destination <= '0;
    end else if (xfer_take && xfer_kind_i != BRS_EV_BRANCH) begin
      if (xfer_with_branch_i) begin
        last_exception_source <= branch_source_i;
        last_exception_destination <= branch_dest_i;
      end else begin
        last_exception_source <= last_branch_source;
        last_exception_destination <= last_branch_dest;
      end
    end
  end

  // last branch copy follows every recorded transfer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_branch_source <= '0;
      last_branch_dest <= '0;
    end else if (xfer_take) begin
      last_branch_source <= xfer_source_i;
      last_branch_dest <= xfer_dest_i;
    end
  end

  // control register: software write, hardware clears recording on debug exception
  assign reg_sel = decode_reg(reg_addr_i);
  assign ctrl_write = reg_write_i && reg_sel == SEL_CONTROL;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      debug_trace_control <= `BRS_CTRL_RESET;
    end else begin
      if (ctrl_write) begin
        debug_trace_control <= reg_wdata_i & `BRS_CTRL_WRITE_MASK;
      end
      // hardware clear wins so a breakpoint freezes the trace
      if (debug_exception_i) begin
        debug_trace_control[`BRS_BIT_RECORD_EN] <= 1'b0;
      end
    end
  end

  assign step_on_branch_flag_o = debug_trace_control[`BRS_BIT_STEP_BRANCH];
  assign feature_flags_o = 32'h1 << `BRS_FEATURE_DS_BIT;

  // trace message port: one pulse per pushed record while messages are on
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trace_message_valid_o <= 1'b0;
      trace_message_o <= '0;
    end else begin
      trace_message_valid_o <= push && debug_trace_control[`BRS_BIT_TRACE_MSG];
      if (push) begin
        trace_message_o <= push_record;
      end
    end
  end

  // trace store request toward the memory logging engine
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trace_store_valid_o <= 1'b0;
    end else begin
      trace_store_valid_o <= push && debug_trace_control[`BRS_BIT_TRACE_STORE];
    end
  end

  // a full store either interrupts or lets the engine wrap, never both
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      buffer_full_irq_o <= 1'b0;
      store_wrap_o <= 1'b0;
    end else begin
      buffer_full_irq_o <= store_full_i && debug_trace_control[`BRS_BIT_TRACE_STORE]
                           && debug_trace_control[`BRS_BIT_BUF_FULL_IRQ];
      store_wrap_o <= store_full_i && debug_trace_control[`BRS_BIT_TRACE_STORE]
                      && !debug_trace_control[`BRS_BIT_BUF_FULL_IRQ];
    end
  end

  // register reads; writes to stack and pointer have no effect
  assign read_index = reg_addr_i[PW-1:0];
  always_comb begin
    case (reg_sel)
      SEL_STACK:   next_rdata = stack_mem[read_index];
      SEL_POINTER: next_rdata = 64'(stack_top_pointer);
      SEL_CONTROL: next_rdata = debug_trace_control;
      SEL_EXC_SRC: next_rdata = 64'(last_exception_source);
      SEL_EXC_DST: next_rdata = 64'(last_exception_destination);
      default:     next_rdata = '0;
    endcase
  end

  // read data holds until the next read, so a slow consumer can still take it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_read_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_read_i;
    end
  end

endmodule

// >>> verif/brs_branch_record_stack_asserts.sv
`timescale 1ns/1ns
module brs_branch_record_stack_asserts #(
  parameter int DEPTH = 8
) (
  // clock, reset and stimulus
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic xfer_valid_i,
  input wire brs_pkg::brs_addr_type xfer_source_i,
  input wire brs_pkg::brs_addr_type xfer_dest_i,
  input wire logic xfer_with_branch_i,
  input wire logic debug_exception_i,
  input wire logic reg_read_i,
  input wire logic reg_write_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [63:0] reg_wdata_i,
  input wire logic store_full_i,
  // design outputs
  input wire logic reg_rvalid_o,
  input wire logic xfer_ready_o,
  input wire logic step_on_branch_flag_o,
  input wire logic trace_message_valid_o,
  input wire logic [63:0] trace_message_o,
  input wire logic trace_store_valid_o,
  input wire logic store_wrap_o,
  input wire logic buffer_full_irq_o
);
  import brs_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rd; reg_read_i |=> reg_rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rv; reg_rvalid_o |-> $past(reg_read_i); endproperty
  a_rv: assert property (p_rv) else $error("answer without read");
  property p_step; reg_write_i && reg_addr_i == 12'h1d9 |=>
    step_on_branch_flag_o == $past(reg_wdata_i[1]); endproperty
  a_step: assert property (p_step) else $error("step flag not written");
  property p_pair; $fell(xfer_ready_o) |=> xfer_ready_o; endproperty
  a_pair: assert property (p_pair) else $error("second push too long");
  property p_cause; !xfer_ready_o |-> $past(xfer_valid_i && xfer_with_branch_i); endproperty
  a_cause: assert property (p_cause) else $error("stall without pair");
  property p_msg; trace_message_valid_o && $past(xfer_valid_i && xfer_ready_o &&
    !xfer_with_branch_i) |-> trace_message_o == {$past(xfer_dest_i), $past(xfer_source_i)};
  endproperty
  a_msg: assert property (p_msg) else $error("trace message content");
  property p_full; (buffer_full_irq_o || store_wrap_o) |->
    $past(store_full_i) && !(buffer_full_irq_o && store_wrap_o); endproperty
  a_full: assert property (p_full) else $error("full handling");
  property p_dbg; debug_exception_i ##1 (xfer_valid_i && xfer_ready_o) |=>
    !trace_message_valid_o && !trace_store_valid_o; endproperty
  a_dbg: assert property (p_dbg) else $error("recording after debug");
  c_pair: cover property (!xfer_ready_o);
  c_irq: cover property (buffer_full_irq_o);
  c_wrap: cover property (store_wrap_o);
endmodule

bind brs_branch_record_stack brs_branch_record_stack_asserts #(.DEPTH(DEPTH)) brs_chk (
  .clk_i, .reset_i, .xfer_valid_i, .xfer_source_i, .xfer_dest_i, .xfer_with_branch_i,
  .debug_exception_i, .reg_read_i, .reg_write_i, .reg_addr_i, .reg_wdata_i, .store_full_i,
  .reg_rvalid_o, .xfer_ready_o, .step_on_branch_flag_o, .trace_message_valid_o,
  .trace_message_o, .trace_store_valid_o, .store_wrap_o, .buffer_full_irq_o);

// >>> verif/brs_pipe_model.sv
`timescale 1ns/1ns
module brs_pipe_model (
  // core side
  input wire logic clk_i,
  input wire logic xfer_ready_i,
  // retired transfers
  output brs_pkg::brs_event_type xfer_kind_o,
  output brs_pkg::brs_addr_type xfer_source_o,
  output brs_pkg::brs_addr_type xfer_dest_o,
  output brs_pkg::brs_addr_type branch_source_o,
  output brs_pkg::brs_addr_type branch_dest_o,
  output logic xfer_valid_o,
  output logic xfer_with_branch_o
);
  import brs_pkg::*;
  initial begin
    xfer_valid_o = 1'b0;
    xfer_with_branch_o = 1'b0;
    xfer_kind_o = BRS_EV_BRANCH;
    {xfer_source_o, xfer_dest_o, branch_source_o, branch_dest_o} = '0;
  end
  // gap gives slow answers; idle lines are inverted so stale data never looks fresh
  task automatic send(input brs_event_type k, input brs_addr_type s, d,
                      input logic wb, input brs_addr_type bs, bd, input int gap);
    @(posedge clk_i) #1;
    repeat (gap) @(posedge clk_i) #1;
    xfer_kind_o = k;
    {xfer_source_o, xfer_dest_o} = {s, d};
    {xfer_with_branch_o, branch_source_o, branch_dest_o} = {wb, bs, bd};
    xfer_valid_o = 1'b1;
    while (!xfer_ready_i) @(posedge clk_i) #1;
    @(posedge clk_i) #1;
    xfer_valid_o = 1'b0;
    {xfer_source_o, xfer_dest_o, branch_source_o, branch_dest_o} = ~{s, d, bs, bd};
  endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import brs_pkg::*;
  localparam int DEPTH = 8;
  logic clk_i, reset_i, debug_exception_i, reg_read_i, reg_write_i, store_full_i;
  logic reg_rvalid_o, xfer_ready_o, step_on_branch_flag_o, trace_message_valid_o;
  logic trace_store_valid_o, store_wrap_o, buffer_full_irq_o, xfer_valid_i, xfer_with_branch_i;
  logic [11:0] reg_addr_i;
  logic [63:0] reg_wdata_i, reg_rdata_o, trace_message_o, lb, le, stk [DEPTH];
  logic [31:0] feature_flags_o, seed, s, d, bs, bd;
  brs_event_type xfer_kind_i;
  brs_addr_type xfer_source_i, xfer_dest_i, branch_source_i, branch_dest_i;
  int err_total, n_checks, ptr;
  brs_branch_record_stack #(.DEPTH(DEPTH)) brs_branch_record_stack_inst (.clk_i, .reset_i,
    .xfer_valid_i, .xfer_kind_i, .xfer_source_i, .xfer_dest_i, .xfer_with_branch_i,
    .branch_source_i, .branch_dest_i, .debug_exception_i, .reg_read_i, .reg_write_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .store_full_i, .xfer_ready_o,
    .step_on_branch_flag_o, .trace_message_valid_o, .trace_message_o, .trace_store_valid_o,
    .store_wrap_o, .buffer_full_irq_o, .feature_flags_o);
  brs_pipe_model brs_pipe_model_inst (.clk_i, .xfer_ready_i(xfer_ready_o),
    .xfer_kind_o(xfer_kind_i), .xfer_source_o(xfer_source_i), .xfer_dest_o(xfer_dest_i),
    .branch_source_o(branch_source_i), .branch_dest_o(branch_dest_i),
    .xfer_valid_o(xfer_valid_i), .xfer_with_branch_o(xfer_with_branch_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [63:0] v);
    @(posedge clk_i) #1;
    {reg_addr_i, reg_wdata_i, reg_write_i} = {a, v, 1'b1};
    @(posedge clk_i) #1;
    reg_write_i = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    @(posedge clk_i) #1;
    {reg_addr_i, reg_read_i} = {a, 1'b1};
    @(posedge clk_i) #1;
    reg_read_i = 1'b0;
    cmp(64'(reg_rvalid_o), 64'h1);
    cmp(reg_rdata_o, exp);
  endtask
  task automatic push(input logic [31:0] hi, lo);
    ptr = (ptr + 1) % DEPTH;
    stk[ptr] = {hi, lo};
  endtask
  // rec: recording is on, msg: trace messages are on
  task automatic tx(input int k, input logic wb, rec, msg);
    seed = lfsr(seed);
    {s, d, bs, bd} = {seed, ~seed, {seed[15:0], seed[31:16]}, seed ^ 32'h00ff_f00f};
    brs_pipe_model_inst.send(brs_event_type'(k), s, d, wb, bs, bd, k);
    if (rec && k != 0) le = wb ? {bd, bs} : lb;
    if (rec) lb = {d, s};
    if (wb) begin
      if (rec) push(bd, bs);
      if (msg) cmp(trace_message_o, {bd, bs});
      @(posedge clk_i) #1;
    end
    if (rec) push(d, s);
    cmp(64'(trace_message_valid_o), 64'(msg));
    if (msg) cmp(trace_message_o, {d, s});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {debug_exception_i, reg_read_i, reg_write_i, store_full_i, reg_addr_i} = '0;
    {reg_wdata_i, lb, le, err_total, n_checks, ptr} = '0;
    seed = 32'h0000_0032;
    reset_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 reset_i = 1'b0;
    cmp(64'(feature_flags_o), 64'h0000_0000_0020_0000);
    rd(12'h1d9, 64'h0);
    rd(12'h1c9, 64'h0);
    wr(12'h1d9, '1);
    cmp(64'(step_on_branch_flag_o), 64'h1);
    rd(12'h1d9, 64'h1c3);
    wr(12'h1d9, 64'h041);
    for (int i = 0; i < 11; i++) tx(i % 3, 1'b0, 1'b1, 1'b1);
    rd(12'h1dd, {32'h0, le[31:0]});
    rd(12'h1de, {32'h0, le[63:32]});
    tx(2, 1'b1, 1'b1, 1'b1);
    rd(12'h1dd, {32'h0, le[31:0]});
    rd(12'h1de, {32'h0, le[63:32]});
    tx(1, 1'b1, 1'b1, 1'b1);
    wr(12'h1c9, 64'h5);
    wr(12'h040, '1);
    rd(12'h1c9, 64'(ptr));
    for (int i = 0; i < DEPTH; i++) rd(12'h040 + 12'(i), stk[i]);
    rd(12'h3ff, 64'h0);
    debug_exception_i = 1'b1;
    fork
      tx(0, 1'b0, 1'b0, 1'b0);
      begin
        @(posedge clk_i) #1;
        debug_exception_i = 1'b0;
      end
    join
    rd(12'h1d9, 64'h040);
    rd(12'h1c9, 64'(ptr));
    wr(12'h1d9, 64'h181);
    tx(0, 1'b0, 1'b1, 1'b0);
    cmp(64'(trace_store_valid_o), 64'h1);
    store_full_i = 1'b1;
    @(posedge clk_i) #1;
    cmp({62'h0, buffer_full_irq_o, store_wrap_o}, 64'h2);
    wr(12'h1d9, 64'h081);
    @(posedge clk_i) #1;
    cmp({62'h0, buffer_full_irq_o, store_wrap_o}, 64'h1);
    store_full_i = 1'b0;
    wrap_up();
  end
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule
